// ### hdl/hbs_flag_cell.sv
// One write-one-to-clear error flag with set priority
`timescale 1ns/10ps
module hbs_flag_cell (
    input  wire logic core_clk,
    input  wire logic reset_n,
    input  wire logic setPulse,
    input  wire logic clearPulse,
    output logic      flagState
);
    import hbs_pkg::*;

    logic flag_ff;
    logic nxt_flag;

    // An event in the clearing cycle must not be lost, so set wins
    always_comb begin
        nxt_flag = flag_ff;
        if (clearPulse) begin
            nxt_flag = 1'b0;
        end
        if (setPulse) begin
            nxt_flag = 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            flag_ff <= 1'b0;
        end else begin
            flag_ff <= nxt_flag;
        end
    end

    assign flagState = flag_ff;

    a_set_wins_clear : assert property (@(posedge core_clk) disable iff (!reset_n)
        setPulse && clearPulse |=> flagState)
        else $error("flag lost an event during a clear");
endmodule // hbs_flag_cell

// ### hdl/hbs_pkg.sv
// Constants for the host-bridge status and class-code register slice
package hbs_pkg;
    localparam int          CFG_ADDR_W     = 8;
    localparam int          CFG_DATA_W     = 8;
    localparam int          STATUS_W       = 16;
    localparam int          NUM_COND       = 4;

    // Byte offsets in configuration space
    localparam logic [7:0]  OFF_STATUS_LO  = 8'h06;
    localparam logic [7:0]  OFF_STATUS_HI  = 8'h07;
    localparam logic [7:0]  OFF_REVISION   = 8'h08;
    localparam logic [7:0]  OFF_SUB_CLASS  = 8'h0A;
    localparam logic [7:0]  OFF_BASE_CLASS = 8'h0B;
    localparam logic [7:0]  OFF_CAP_PTR    = 8'h34;

    // Status field positions
    localparam int          BIT_SYS_ERR    = 14;
    localparam int          BIT_MST_ABORT  = 13;
    localparam int          BIT_TGT_ABORT  = 12;
    localparam int          BIT_SIG_ABORT  = 11;
    localparam int          BIT_SEL_HI     = 10;
    localparam int          BIT_SEL_LO     = 9;
    localparam int          BIT_PARITY_ERR = 8;
    localparam int          BIT_FAST_B2B   = 7;
    localparam int          BIT_CAP_LIST   = 4;

    // Reset and fixed values
    localparam logic [15:0] STATUS_RESET   = 16'h0090;
    localparam logic [15:0] STATUS_FIXED   = 16'h0090;
    localparam logic [15:0] STATUS_RSVD    = 16'h806F;
    localparam logic [1:0]  SEL_TIMING_VAL = 2'h0;
    localparam logic [7:0]  SUB_CLASS_VAL  = 8'h00;
    localparam logic [7:0]  BASE_CLASS_VAL = 8'h06;
    localparam logic [7:0]  UNMAPPED_VAL   = 8'h00;
    // Arbitrary revision value, not a real stepping
    localparam logic [7:0]  REVISION_DFLT  = 8'h01;
endpackage

// ### hdl/hbs_serr_gate.sv
// Gates device error conditions into system-error messages on the hub link
`timescale 1ns/10ps
module hbs_serr_gate #(
    parameter int NUM_COND = hbs_pkg::NUM_COND
) (
    input  wire logic                core_clk,
    input  wire logic                reset_n,
    input  wire logic [NUM_COND-1:0] errorEvent,
    input  wire logic [NUM_COND-1:0] errCmdEnable,
    input  wire logic                systemErrorEnable,
    output logic                     serrMsgSend
);
    import hbs_pkg::*;

    logic msg_ff;
    logic nxt_msg;

    // Global enable and per-condition enables both required
    always_comb begin
        nxt_msg = systemErrorEnable && (|(errorEvent & errCmdEnable)); // RULE12 RULE16
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            msg_ff <= 1'b0;
        end else begin
            msg_ff <= nxt_msg;
        end
    end

    assign serrMsgSend = msg_ff;

    a_no_msg_disabled : assert property (@(posedge core_clk) disable iff (!reset_n) // RULE16
        !systemErrorEnable |=> !serrMsgSend)
        else $error("system-error message sent while globally disabled");

    a_msg_needs_cond : assert property (@(posedge core_clk) disable iff (!reset_n) // RULE12
        serrMsgSend |-> $past(|(errorEvent & errCmdEnable)) && $past(systemErrorEnable))
        else $error("system-error message without an enabled condition");

    a_msg_on_cond : assert property (@(posedge core_clk) disable iff (!reset_n) // RULE12
        systemErrorEnable && (|(errorEvent & errCmdEnable)) |=> serrMsgSend)
        else $error("enabled condition produced no system-error message");
endmodule // hbs_serr_gate

// ### hdl/hbs_status_regs.sv
// Host-bridge status, revision and class-code configuration registers
// What this block does
// RULE1 - Sending system-error message sets bit 14
// RULE2 - Writing one clears bit 14; zero keeps
// RULE3 - Master-abort completion received sets bit 13
// RULE4 - Target-abort completion received sets bit 12
// RULE5 - Bits 13, 12 clear on written one
// RULE6 - Bit 11 reads zero, ignores writes
// RULE7 - Bits 10:9 read 00, ignore writes
// RULE8 - Bit 8 reads zero, ignores writes
// RULE9 - Bit 7 reads one, ignores writes
// RULE10 - Bit 4 reads one: capability list
// RULE11 - Sixteen-bit status at 06h, resets 0090h
// RULE12 - Error reporting gated by command enables
// RULE13 - Revision at 08h is fixed, read-only
// RULE14 - Sub-class at 0Ah reads 00h
// RULE15 - Base-class at 0Bh reads 06h
// RULE16 - System-error enable low blocks messages
// RULE17 - Reserved status bits read zero
`timescale 1ns/10ps
module hbs_status_regs #(
    parameter int                      NUM_COND      = hbs_pkg::NUM_COND,
    // Arbitrary stepping code, set per silicon revision
    parameter logic [7:0]              REVISION_CODE = hbs_pkg::REVISION_DFLT
) (
    input  wire logic                          core_clk,
    input  wire logic                          reset_n,
    input  wire logic [hbs_pkg::CFG_ADDR_W-1:0] cfgAddr,
    input  wire logic                          cfgWrEn,
    input  wire logic [hbs_pkg::CFG_DATA_W-1:0] cfgWrData,
    input  wire logic                          cfgRdEn,
    output logic      [hbs_pkg::CFG_DATA_W-1:0] cfgRdData,
    output logic                               cfgRdValid,
    input  wire logic [NUM_COND-1:0]           errorEvent,
    input  wire logic [NUM_COND-1:0]           errCmdEnable,
    input  wire logic                          systemErrorEnable,
    input  wire logic                          masterAbortRcvd,
    input  wire logic                          targetAbortRcvd,
    output logic                               serrMsgSend,
    output logic      [hbs_pkg::STATUS_W-1:0]   bridgeErrorStatus
);
    import hbs_pkg::*;

    // Write-one-to-clear hit on a status bit in the upper byte
    function automatic logic w1cHit(input logic       wrEn,
                                    input logic [7:0] addr,
                                    input logic [7:0] data,
                                    input int         bitPos);
        logic hit;
        hit = 1'b0;
        if (wrEn && (addr == OFF_STATUS_HI)) begin
            hit = data[bitPos-8];
        end
        return hit;
    endfunction

    logic signalledSystemErrorFlag;
    logic receivedMasterAbortFlag;
    logic receivedTargetAbortFlag;
    logic clrSysErr;
    logic clrMstAbort;
    logic clrTgtAbort;
    logic [15:0] statusWord;

    // Write side: only three bits are writable and only by clearing
    always_comb begin
        clrSysErr   = w1cHit(cfgWrEn, cfgAddr, cfgWrData, BIT_SYS_ERR);   // RULE2
        clrMstAbort = w1cHit(cfgWrEn, cfgAddr, cfgWrData, BIT_MST_ABORT); // RULE5
        clrTgtAbort = w1cHit(cfgWrEn, cfgAddr, cfgWrData, BIT_TGT_ABORT); // RULE5
    end

    hbs_serr_gate #(
        .NUM_COND          (NUM_COND)
    ) u_serr_gate (
        .core_clk          (core_clk),
        .reset_n           (reset_n),
        .errorEvent        (errorEvent),
        .errCmdEnable      (errCmdEnable),
        .systemErrorEnable (systemErrorEnable),
        .serrMsgSend       (serrMsgSend)
    );

    // Flag follows the message actually sent, so it obeys the enables too
    hbs_flag_cell u_sys_err_flag (
        .core_clk   (core_clk),
        .reset_n    (reset_n),
        .setPulse   (serrMsgSend), // RULE1
        .clearPulse (clrSysErr),
        .flagState  (signalledSystemErrorFlag)
    );

    hbs_flag_cell u_mst_abort_flag (
        .core_clk   (core_clk),
        .reset_n    (reset_n),
        .setPulse   (masterAbortRcvd), // RULE3
        .clearPulse (clrMstAbort),
        .flagState  (receivedMasterAbortFlag)
    );

    hbs_flag_cell u_tgt_abort_flag (
        .core_clk   (core_clk),
        .reset_n    (reset_n),
        .setPulse   (targetAbortRcvd), // RULE4
        .clearPulse (clrTgtAbort),
        .flagState  (receivedTargetAbortFlag)
    );

    // Hardwired fields come from constants; writes never reach them
    always_comb begin
        statusWord                        = STATUS_FIXED; // RULE9 RULE10 RULE17
        statusWord[BIT_SIG_ABORT]         = 1'b0;         // RULE6
        statusWord[BIT_SEL_HI:BIT_SEL_LO] = SEL_TIMING_VAL; // RULE7
        statusWord[BIT_PARITY_ERR]        = 1'b0;         // RULE8
        statusWord[BIT_SYS_ERR]           = signalledSystemErrorFlag;
        statusWord[BIT_MST_ABORT]         = receivedMasterAbortFlag;
        statusWord[BIT_TGT_ABORT]         = receivedTargetAbortFlag;
    end

    assign bridgeErrorStatus = statusWord; // RULE11

    // Read side: one-cycle registered answer, no side effects
    logic [7:0] rdData_ff;
    logic [7:0] nxt_rdData;
    logic       rdValid_ff;
    logic       nxt_rdValid;

    always_comb begin
        nxt_rdData  = rdData_ff;
        nxt_rdValid = cfgRdEn;
        if (cfgRdEn) begin
            case (cfgAddr)
                OFF_STATUS_LO:  nxt_rdData = statusWord[7:0];   // RULE11
                OFF_STATUS_HI:  nxt_rdData = statusWord[15:8];  // RULE11
                OFF_REVISION:   nxt_rdData = REVISION_CODE;     // RULE13
                OFF_SUB_CLASS:  nxt_rdData = SUB_CLASS_VAL;     // RULE14
                OFF_BASE_CLASS: nxt_rdData = BASE_CLASS_VAL;    // RULE15
                default:        nxt_rdData = UNMAPPED_VAL;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            rdData_ff  <= 8'h00;
            rdValid_ff <= 1'b0;
        end else begin
            rdData_ff  <= nxt_rdData;
            rdValid_ff <= nxt_rdValid;
        end
    end

    assign cfgRdData  = rdData_ff;
    assign cfgRdValid = rdValid_ff;

    // Checks
    sequence s_clear_sys_err;
        cfgWrEn && (cfgAddr == OFF_STATUS_HI) && cfgWrData[BIT_SYS_ERR-8] && !serrMsgSend;
    endsequence

    sequence s_keep_sys_err;
        cfgWrEn && (cfgAddr == OFF_STATUS_HI) && !cfgWrData[BIT_SYS_ERR-8] && signalledSystemErrorFlag;
    endsequence

    sequence s_clear_aborts;
        cfgWrEn && (cfgAddr == OFF_STATUS_HI) && cfgWrData[BIT_MST_ABORT-8] && cfgWrData[BIT_TGT_ABORT-8]
            && !masterAbortRcvd && !targetAbortRcvd;
    endsequence

    sequence s_read_at(logic [7:0] off);
        cfgRdEn && (cfgAddr == off);
    endsequence

    a_syserr_set_msg : assert property (@(posedge core_clk) disable iff (!reset_n) // RULE1
        serrMsgSend |=> bridgeErrorStatus[BIT_SYS_ERR])
        else $error("signalled system error not set by message");

    a_syserr_w1c : assert property (@(posedge core_clk) disable iff (!reset_n) // RULE2
        s_clear_sys_err |=> !bridgeErrorStatus[BIT_SYS_ERR])
        else $error("signalled system error not cleared by write of one");

    a_syserr_zero_keeps : assert property (@(posedge core_clk) disable iff (!reset_n) // RULE2
        s_keep_sys_err |=> bridgeErrorStatus[BIT_SYS_ERR])
        else $error("signalled system error lost on write of zero");

    a_mst_abort_set : assert property (@(posedge core_clk) disable iff (!reset_n) // RULE3
        masterAbortRcvd |=> bridgeErrorStatus[BIT_MST_ABORT])
        else $error("received master abort not recorded");

    a_tgt_abort_set : assert property (@(posedge core_clk) disable iff (!reset_n) // RULE4
        targetAbortRcvd |=> bridgeErrorStatus[BIT_TGT_ABORT])
        else $error("received target abort not recorded");

    a_abort_w1c : assert property (@(posedge core_clk) disable iff (!reset_n) // RULE5
        s_clear_aborts |=> !bridgeErrorStatus[BIT_MST_ABORT] && !bridgeErrorStatus[BIT_TGT_ABORT])
        else $error("abort flags not cleared by write of one");

    a_abort_hold : assert property (@(posedge core_clk) disable iff (!reset_n) // RULE5
        !masterAbortRcvd && !w1cHit(cfgWrEn, cfgAddr, cfgWrData, BIT_MST_ABORT)
        |=> bridgeErrorStatus[BIT_MST_ABORT] == $past(bridgeErrorStatus[BIT_MST_ABORT]))
        else $error("master abort flag changed without cause");

    a_fixed_bits : assert property (@(posedge core_clk) disable iff (!reset_n) // RULE6
        cfgWrEn |=> bridgeErrorStatus[BIT_SIG_ABORT:BIT_PARITY_ERR] == 4'h0 && bridgeErrorStatus[BIT_FAST_B2B]) // RULE7
        else $error("hardwired status bits moved after write"); // RULE8 RULE9

    a_cap_bit : assert property (@(posedge core_clk) disable iff (!reset_n) // RULE10
        s_read_at(OFF_STATUS_LO) |=> cfgRdValid && cfgRdData[BIT_CAP_LIST])
        else $error("capability list bit does not read one");

    a_reset_value : assert property (@(posedge core_clk) disable iff (!reset_n) // RULE11
        $rose(reset_n) |-> bridgeErrorStatus == STATUS_RESET)
        else $error("status does not come out of reset at its default");

    a_rsvd_zero : assert property (@(posedge core_clk) disable iff (!reset_n) // RULE17
        s_read_at(OFF_STATUS_HI) |=> cfgRdValid && (cfgRdData & STATUS_RSVD[15:8]) == 8'h00
            && cfgRdData[BIT_SYS_ERR-8] == $past(signalledSystemErrorFlag))
        else $error("reserved status bits or flag read wrong");

    a_rev_read : assert property (@(posedge core_clk) disable iff (!reset_n) // RULE13
        s_read_at(OFF_REVISION) |=> cfgRdValid && cfgRdData == REVISION_CODE)
        else $error("revision code read wrong");

    a_sub_class : assert property (@(posedge core_clk) disable iff (!reset_n) // RULE14
        s_read_at(OFF_SUB_CLASS) |=> cfgRdValid && cfgRdData == SUB_CLASS_VAL)
        else $error("sub-class code read wrong");

    a_base_class : assert property (@(posedge core_clk) disable iff (!reset_n) // RULE15
        s_read_at(OFF_BASE_CLASS) |=> cfgRdValid && cfgRdData == BASE_CLASS_VAL)
        else $error("base-class code read wrong");

    a_syserr_needs_en : assert property (@(posedge core_clk) disable iff (!reset_n) // RULE16
        (!systemErrorEnable)[*2] ##0 !bridgeErrorStatus[BIT_SYS_ERR] |=> !bridgeErrorStatus[BIT_SYS_ERR])
        else $error("signalled system error set while disabled");
endmodule // hbs_status_regs

// ### verification/hbs_hub_model.sv
// Hub-side partner: takes system-error messages and returns abort completions
`timescale 1ns/10ps
module hbs_hub_model (
    input  wire logic       core_clk,
    input  wire logic       reset_n,
    input  wire logic       serrMsgSend,
    input  wire logic       sendMasterAbort,
    input  wire logic       sendTargetAbort,
    input  wire logic [3:0] replyDelay,
    output logic            masterAbortRcvd,
    output logic            targetAbortRcvd,
    output int              serrCount
);
    initial begin
        masterAbortRcvd = 1'b0;
        targetAbortRcvd = 1'b0;
        serrCount = 0;
    end
    // Each message cycle counts once, so a stretched pulse shows as extra messages
    always @(posedge core_clk) begin
        if (!reset_n) begin
            serrCount <= 0;
        end else if (serrMsgSend === 1'b1) begin
            serrCount <= serrCount + 1;
        end
    end
    // Completions may come back promptly or after a wait, as a real hub would
    always @(posedge core_clk) begin
        if (sendMasterAbort) begin
            repeat (replyDelay) @(posedge core_clk);
            masterAbortRcvd <= 1'b1;
            @(posedge core_clk);
            masterAbortRcvd <= 1'b0;
        end
    end
    always @(posedge core_clk) begin
        if (sendTargetAbort) begin
            repeat (replyDelay) @(posedge core_clk);
            targetAbortRcvd <= 1'b1;
            @(posedge core_clk);
            targetAbortRcvd <= 1'b0;
        end
    end
endmodule // hbs_hub_model

// ### verification/test_host_bridge_status_class_regs.sv
// Self-checking bench for the host-bridge status and class-code registers
`timescale 1ns/10ps
module test_host_bridge_status_class_regs;
    import hbs_pkg::*;
    // Arbitrary stepping code for this run
    localparam logic [7:0] REV_CODE = 8'h3C;
    logic                core_clk = 1'b0;
    logic                reset_n = 1'b0;
    logic [7:0]          cfgAddr = 8'h00;
    logic                cfgWrEn = 1'b0;
    logic [7:0]          cfgWrData = 8'h00;
    logic                cfgRdEn = 1'b0;
    logic [7:0]          cfgRdData;
    logic                cfgRdValid;
    logic [NUM_COND-1:0] errorEvent = '0;
    logic [NUM_COND-1:0] errCmdEnable = '0;
    logic                systemErrorEnable = 1'b0;
    logic                masterAbortRcvd;
    logic                targetAbortRcvd;
    logic                serrMsgSend;
    logic [15:0]         bridgeErrorStatus;
    logic                sendMasterAbort = 1'b0;
    logic                sendTargetAbort = 1'b0;
    logic [3:0]          replyDelay = 4'h0;
    int                  serrCount;
    int                  fails = 0;
    int                  samplesChecked = 0;

    always #5 core_clk = ~core_clk;

    hbs_status_regs #(.NUM_COND(NUM_COND), .REVISION_CODE(REV_CODE)) i_dut (
        .core_clk(core_clk), .reset_n(reset_n), .cfgAddr(cfgAddr), .cfgWrEn(cfgWrEn),
        .cfgWrData(cfgWrData), .cfgRdEn(cfgRdEn), .cfgRdData(cfgRdData), .cfgRdValid(cfgRdValid),
        .errorEvent(errorEvent), .errCmdEnable(errCmdEnable), .systemErrorEnable(systemErrorEnable),
        .masterAbortRcvd(masterAbortRcvd), .targetAbortRcvd(targetAbortRcvd),
        .serrMsgSend(serrMsgSend), .bridgeErrorStatus(bridgeErrorStatus));

    hbs_hub_model i_hub (
        .core_clk(core_clk), .reset_n(reset_n), .serrMsgSend(serrMsgSend),
        .sendMasterAbort(sendMasterAbort), .sendTargetAbort(sendTargetAbort), .replyDelay(replyDelay),
        .masterAbortRcvd(masterAbortRcvd), .targetAbortRcvd(targetAbortRcvd), .serrCount(serrCount));

    task automatic tally_and_finish;
        $display("Comparisons %0d, mismatches %0d", samplesChecked, fails);
        if (fails == 0 && samplesChecked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic cfg_write(input logic [7:0] addr, input logic [7:0] data);
        @(posedge core_clk);
        cfgWrEn   <= 1'b1;
        cfgAddr   <= addr;
        cfgWrData <= data;
        @(posedge core_clk);
        cfgWrEn   <= 1'b0;
    endtask

    // Read one byte and compare; valid must come exactly one cycle after the strobe
    task automatic read_check(input logic [7:0] addr, input logic [7:0] exp);
        @(posedge core_clk);
        cfgRdEn <= 1'b1;
        cfgAddr <= addr;
        @(posedge core_clk);
        cfgRdEn <= 1'b0;
        #1;
        samplesChecked++;
        if (cfgRdValid !== 1'b1 || cfgRdData !== exp) begin
            fails++;
            $display("Error at %0t: read %h gave %h valid %b, expected %h", $time, addr, cfgRdData, cfgRdValid, exp);
        end
    endtask

    task automatic status_check(input logic [15:0] exp);
        @(posedge core_clk);
        #1;
        samplesChecked++;
        if (bridgeErrorStatus !== exp) begin
            fails++;
            $display("Error at %0t: status %h, expected %h", $time, bridgeErrorStatus, exp);
        end
    endtask

    task automatic count_check(input int exp);
        samplesChecked++;
        if (serrCount !== exp) begin
            fails++;
            $display("Error at %0t: %0d messages, expected %0d", $time, serrCount, exp);
        end
    endtask

    // One-cycle error event under the given enables, then time for message and flag
    task automatic fire_event(input logic sysEn, input logic [NUM_COND-1:0] cmdEn, input logic [NUM_COND-1:0] ev);
        @(posedge core_clk);
        systemErrorEnable <= sysEn;
        errCmdEnable      <= cmdEn;
        errorEvent        <= ev;
        @(posedge core_clk);
        errorEvent        <= '0;
        repeat (4) @(posedge core_clk);
    endtask

    task automatic t_reset_values;
        status_check(16'h0090);
        read_check(8'h06, 8'h90);
        read_check(8'h07, 8'h00);
        read_check(8'h08, REV_CODE);
        read_check(8'h0A, 8'h00);
        read_check(8'h0B, 8'h06);
        read_check(8'h09, 8'h00);
    endtask

    task automatic t_serr_gated;
        fire_event(1'b0, 4'hF, 4'hF);
        count_check(0);
        status_check(16'h0090);
        fire_event(1'b1, 4'h0, 4'hF);
        count_check(0);
        fire_event(1'b1, 4'hD, 4'h2);
        count_check(0);
        status_check(16'h0090);
    endtask

    task automatic t_serr_send;
        fire_event(1'b1, 4'h4, 4'h4);
        count_check(1);
        status_check(16'h4090);
    endtask

    task automatic t_aborts;
        replyDelay <= 4'h0;
        @(posedge core_clk);
        sendMasterAbort <= 1'b1;
        @(posedge core_clk);
        sendMasterAbort <= 1'b0;
        repeat (3) @(posedge core_clk);
        status_check(16'h6090);
        replyDelay <= 4'h5;
        sendTargetAbort <= 1'b1;
        @(posedge core_clk);
        sendTargetAbort <= 1'b0;
        repeat (9) @(posedge core_clk);
        status_check(16'h7090);
        // Zeros on the clearable bits and ones everywhere else must change nothing
        cfg_write(8'h07, 8'h8F);
        cfg_write(8'h06, 8'hFF);
        status_check(16'h7090);
        read_check(8'h07, 8'h70);
        read_check(8'h06, 8'h90);
        cfg_write(8'h07, 8'h20);
        status_check(16'h5090);
        cfg_write(8'h07, 8'h40);
        status_check(16'h1090);
        cfg_write(8'h07, 8'h10);
        status_check(16'h0090);
    endtask

    task automatic t_read_only;
        cfg_write(8'h08, 8'hFF);
        cfg_write(8'h0A, 8'hFF);
        cfg_write(8'h0B, 8'hFF);
        read_check(8'h08, REV_CODE);
        read_check(8'h0A, 8'h00);
        read_check(8'h0B, 8'h06);
        status_check(16'h0090);
    endtask

    initial begin
        repeat (8) @(posedge core_clk);
        reset_n <= 1'b1;
        t_reset_values();
        t_serr_gated();
        t_serr_send();
        t_aborts();
        t_read_only();
        tally_and_finish();
    end

    // Whole sequence needs about a hundred cycles
    initial begin
        #20000;
        fails++;
        $display("Error at %0t: watchdog expired", $time);
        tally_and_finish();
    end
endmodule // test_host_bridge_status_class_regs
